//--- adc_pin_io_sync_error_ctrl_tb_top.sv
// self-checking bench for the pin io block over axi4-lite
`timescale 1ns/1ps
`include "aps_defs.svh"
module adc_pin_io_sync_error_ctrl_tb_top;
    logic core_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, gp_o, gp_oe, gp_i, resp;
    logic se_i, se_o, se_oe, adc_err, filt_rst, irq, line_low = 1'b0, pin1_lvl = 1'b0;
    logic [3:0] stat_err = 4'h0, seen;
    logic [31:0] rd, s1;
    int errors = 0;
    int total_checks = 0;
    always #2.5 core_clk_i = ~core_clk_i;
    aps_pin_io aps_pin_io_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sync_err_pin_i(se_i), .sync_err_pin_o(se_o), .sync_err_pin_oe_o(se_oe),
        .general_pin_o(gp_o), .general_pin_oe_o(gp_oe), .general_pin_i(gp_i),
        .status_err_i(stat_err), .adc_error_o(adc_err), .filter_reset_o(filt_rst), .irq_o(irq));
    aps_pin_partner aps_pin_partner_inst (.core_clk_i(core_clk_i), .sync_err_pin_o(se_o),
        .sync_err_pin_oe_o(se_oe), .general_pin_o(gp_o), .general_pin_oe_o(gp_oe),
        .line_low_i(line_low), .pin1_level_i(pin1_lvl), .sync_err_pin_i(se_i),
        .general_pin_i(gp_i));
    task finish_test();
        if (errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [31:0] act, input logic [31:0] exp);
        total_checks++;
        if (act !== exp) begin
            errors++;
            $display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // both channels offered together, each dropped at its own handshake edge
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (1) begin
            @(posedge core_clk_i);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
            if (n > 100) begin
                errors++;
                finish_test();
            end
        end
        // one spare edge so a following call never re-drives a handshake in this step
        @(posedge core_clk_i);
    endtask
    task rdr(input logic [7:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (1) begin
            @(posedge core_clk_i);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
            if (n > 100) begin
                errors++;
                finish_test();
            end
        end
        @(posedge core_clk_i);
    endtask
    // collects which mux select codes appear over a window
    task watch_mux();
        seen = 4'h0;
        repeat (400) begin
            @(posedge core_clk_i);
            seen[gp_o] = 1'b1;
        end
    endtask
    initial begin
        tick(16);
        arst_n_i <= 1'b1;
        tick(1);
        rdr(`APS_PIOC_ADDR);
        // error-data bit reads the pulled-up pin while it is not an output
        chk(rd, 32'h0000_0900);
        chk(irq, 1'b0);
        // unlisted low bits 0-4 written as one; they must not stick
        wr(`APS_PIOC_ADDR, 32'h0000_1f3f);
        rdr(`APS_PIOC_ADDR);
        chk(rd, 32'h0000_1f20);
        tick(2);
        chk({se_oe, se_o}, 2'b11);
        chk(gp_oe, 2'b11);
        wr(`APS_PIOC_ADDR, 32'h0000_1600);
        tick(2);
        chk({se_oe, se_o}, 2'b10);
        wr(`APS_SEQ_ADDR, 32'h0000_008f);
        watch_mux();
        chk(seen, 4'hf);
        wr(`APS_SEQ_ADDR, 32'h0000_0083);
        // let the slot still in flight from four-slot mode finish first
        tick(40);
        watch_mux();
        chk(seen, 4'h3);
        s1 = 32'h0;
        repeat (60) begin
            rdr(`APS_STAT_ADDR);
            s1 = s1 | rd;
        end
        chk(s1[4], 1'b1);
        // error input mode, line pulled low by a neighbour
        wr(`APS_PIOC_ADDR, 32'h0000_0200);
        chk(gp_oe, 2'b00);
        line_low <= 1'b1;
        tick(6);
        chk(adc_err, 1'b1);
        chk(se_oe, 1'b0);
        rdr(`APS_PIOC_ADDR);
        chk(rd[8], 1'b0);
        line_low <= 1'b0;
        tick(6);
        chk(adc_err, 1'b0);
        rdr(`APS_PIOC_ADDR);
        chk(rd[8], 1'b1);
        wr(`APS_PIOC_ADDR, 32'h0000_0000);
        line_low <= 1'b1;
        tick(6);
        chk({adc_err, se_oe}, 2'b00);
        line_low <= 1'b0;
        // open-drain error output follows the other error flags
        wr(`APS_PIOC_ADDR, 32'h0000_0400);
        stat_err <= 4'h4;
        tick(4);
        chk({se_oe, se_o, se_i}, 3'b100);
        stat_err <= 4'h0;
        tick(4);
        chk({se_oe, se_i}, 2'b01);
        // sync hold, sync-rise event raises the interrupt
        // a mask bit of one lets its status bit through; only the sync event here
        wr(`APS_IRQ_MASK_ADDR, 32'h0000_0002);
        wr(`APS_PIOC_ADDR, 32'h0000_0800);
        wr(`APS_IRQ_STAT_ADDR, 32'h0000_0007);
        line_low <= 1'b1;
        tick(6);
        chk(filt_rst, 1'b1);
        chk(irq, 1'b0);
        line_low <= 1'b0;
        tick(6);
        chk({filt_rst, irq}, 2'b01);
        rdr(`APS_IRQ_STAT_ADDR);
        chk(rd[1], 1'b1);
        wr(`APS_IRQ_MASK_ADDR, 32'h0000_0000);
        tick(2);
        chk(irq, 1'b0);
        wr(`APS_IRQ_MASK_ADDR, 32'h0000_0002);
        wr(`APS_IRQ_STAT_ADDR, 32'h0000_0002);
        tick(2);
        chk(irq, 1'b0);
        rdr(`APS_IRQ_STAT_ADDR);
        chk(rd[1], 1'b0);
        // alternate sync: low line freezes the slot, no filter reset
        wr(`APS_SEQ_ADDR, 32'h0000_8003);
        line_low <= 1'b1;
        tick(100);
        rdr(`APS_STAT_ADDR);
        s1 = rd;
        tick(100);
        rdr(`APS_STAT_ADDR);
        chk(rd[1:0], s1[1:0]);
        chk(filt_rst, 1'b0);
        line_low <= 1'b0;
        // pin 1 input enable gates the readable level
        wr(`APS_PIOC_ADDR, 32'h0000_0020);
        pin1_lvl <= 1'b1;
        tick(6);
        rdr(`APS_STAT_ADDR);
        chk(rd[7], 1'b1);
        wr(`APS_PIOC_ADDR, 32'h0000_0000);
        tick(6);
        rdr(`APS_STAT_ADDR);
        chk(rd[7], 1'b0);
        // unmapped place answers with an error
        wr(8'h80, 32'h0000_1234);
        chk(resp, `APS_RESP_SLVERR);
        rdr(8'h80);
        chk(rd, 32'h0000_0000);
        chk(resp, `APS_RESP_SLVERR);
        finish_test();
    end
endmodule

//--- aps_chan_seq.sv
// channel sequencer: steps enabled slots, settles after each switch, obeys sync
`timescale 1ns/1ps
`include "aps_defs.svh"
module aps_chan_seq (
    input wire logic core_clk_i, // device clock
    input wire logic arst_n_i, // async reset, active low
    aps_seq_if.seq sq // controls in, position out
);
    aps_pkg::aps_seq_state_t state_r;
    logic [7:0] cnt_r;
    logic [1:0] slot_r;
    logic step_r;

    function automatic logic [1:0] next_slot(input logic [1:0] cur, input logic [3:0] en);
        logic [1:0] s;
        logic [1:0] r;
        r = cur;
        for (int i = 1; i <= 4; i++) begin
            s = 2'(cur + 2'(i));
            if (en[s] && r == cur) begin
                r = s;
            end
        end
        return r;
    endfunction

    function automatic logic multi(input logic [3:0] en);
        return ($countones(en) > 1);
    endfunction

    // at most four slots: the slot counter is only two bits wide
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= aps_pkg::APS_SEQ_IDLE;
            cnt_r <= 8'h00;
            slot_r <= 2'h0;
            step_r <= 1'b0;
        end else begin
            step_r <= 1'b0;
            if (!sq.run || sq.sync_hold) begin
                state_r <= aps_pkg::APS_SEQ_IDLE;
                cnt_r <= 8'h00;
            end else begin
                case (state_r)
                    aps_pkg::APS_SEQ_IDLE: begin
                        state_r <= aps_pkg::APS_SEQ_SETTLE;
                        cnt_r <= sq.settle_cyc;
                    end
                    aps_pkg::APS_SEQ_SETTLE: begin
                        if (cnt_r == 8'h00) begin
                            state_r <= aps_pkg::APS_SEQ_CONV;
                            cnt_r <= sq.conv_cyc;
                        end else begin
                            cnt_r <= 8'(cnt_r - 8'h01);
                        end
                    end
                    aps_pkg::APS_SEQ_CONV: begin
                        if (cnt_r != 8'h00) begin
                            cnt_r <= 8'(cnt_r - 8'h01);
                        end else if (sq.alt_gate && multi(sq.chan_en)) begin
                            state_r <= aps_pkg::APS_SEQ_HOLD;
                        end else begin
                            slot_r <= next_slot(slot_r, sq.chan_en);
                            step_r <= 1'b1;
                            state_r <= aps_pkg::APS_SEQ_SETTLE;
                            cnt_r <= sq.settle_cyc;
                        end
                    end
                    aps_pkg::APS_SEQ_HOLD: begin
                        if (!sq.alt_gate) begin
                            slot_r <= next_slot(slot_r, sq.chan_en);
                            step_r <= 1'b1;
                            state_r <= aps_pkg::APS_SEQ_SETTLE;
                            cnt_r <= sq.settle_cyc;
                        end
                    end
                    default: begin
                        state_r <= aps_pkg::APS_SEQ_IDLE;
                    end
                endcase
            end
        end
    end

    assign sq.slot = slot_r;
    assign sq.step = step_r;
    assign sq.settling = (state_r == aps_pkg::APS_SEQ_SETTLE);
    assign sq.conv_busy = (state_r == aps_pkg::APS_SEQ_CONV);

    settle_after_step_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        step_r |-> state_r == aps_pkg::APS_SEQ_SETTLE)
        else $error("no settle after mux switch");
    hold_blocks_conv_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        sq.sync_hold |=> state_r == aps_pkg::APS_SEQ_IDLE)
        else $error("sync low did not hold conversion in reset");
    alt_withhold_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (state_r == aps_pkg::APS_SEQ_HOLD && sq.alt_gate && sq.run && !sq.sync_hold)
        |=> state_r == aps_pkg::APS_SEQ_HOLD)
        else $error("conversion started while sync low");
    step_cover_c: cover property (@(posedge core_clk_i) disable iff (!arst_n_i) step_r);
    hold_cover_c: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
        state_r == aps_pkg::APS_SEQ_HOLD ##1 step_r);
endmodule

//--- aps_defs.svh
// register map, field positions, reset values and timing counts for the pin io block
`ifndef APS_DEFS_SVH
`define APS_DEFS_SVH

// printed register index 0x06 is not a multiple of four: byte address is index times four
`define APS_PIOC_IDX 8'h06
`define APS_PIOC_ADDR 8'h18
`define APS_SEQ_ADDR 8'h40
`define APS_IRQ_STAT_ADDR 8'h44
`define APS_IRQ_MASK_ADDR 8'h48
`define APS_STAT_ADDR 8'h4c

`define APS_PIOC_RST 16'h0800
`define APS_PIOC_WMASK 16'h1f20
`define APS_SEQ_RST 16'h0001

`define APS_B_MUX 12
`define APS_B_SYNC 11
`define APS_F_ERR_HI 10
`define APS_F_ERR_LO 9
`define APS_B_ERRDAT 8
`define APS_B_IPEN1 5

`define APS_ERR_OFF 2'h0
`define APS_ERR_IN 2'h1
`define APS_ERR_OD 2'h2
`define APS_ERR_GPO 2'h3

`define APS_NUM_IRQ 3
`define APS_IRQ_ERRIN 0
`define APS_IRQ_SYNC 1
`define APS_IRQ_STEP 2

`define APS_MAX_SEQ 3'h4
`define APS_CONV_CYC 8'h10
`define APS_B_ALT 15
`define APS_RESP_OKAY 2'h0
`define APS_RESP_SLVERR 2'h2
`endif

//--- aps_pin_io.sv
// pin io configuration, sync/error pin and external mux control behind axi4-lite
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "aps_defs.svh"
module aps_pin_io (
    input wire logic core_clk_i, // device clock, 200 MHz
    input wire logic arst_n_i, // async reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic sync_err_pin_i, // sync/error pin level
    output logic sync_err_pin_o, // sync/error pin drive value
    output logic sync_err_pin_oe_o, // sync/error pin drive enable
    output logic [1:0] general_pin_o, // general pins 0/1 drive value
    output logic [1:0] general_pin_oe_o, // general pins drive enable
    input wire logic [1:0] general_pin_i, // general pins level
    input wire logic [3:0] status_err_i, // other status error flags
    output logic adc_error_o, // combined adc error flag
    output logic filter_reset_o, // holds modulator and filter in reset
    output logic irq_o // level interrupt
);
    logic [15:0] pioc_r;
    logic [15:0] seq_r;
    logic [`APS_NUM_IRQ-1:0] irq_stat_r;
    logic [`APS_NUM_IRQ-1:0] irq_mask_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_have_r;
    logic w_have_r;
    logic pin_prev_r;
    logic [1:0] err_mode;
    logic sync_en;
    logic alternate_sync_mode;
    logic wr_fire;
    logic sync_hold;
    logic err_in_evt;
    logic sync_evt;
    logic [`APS_NUM_IRQ-1:0] irq_set;
    logic [`APS_NUM_IRQ-1:0] irq_clr;
    logic [15:0] pioc_rd;
    logic any_err;
    aps_seq_if sq ();

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
        input logic [3:0] st, input logic [15:0] msk);
        logic [15:0] n;
        n = old;
        if (st[0]) begin
            n[7:0] = wd[7:0];
        end
        if (st[1]) begin
            n[15:8] = wd[15:8];
        end
        return (n & msk) | (old & ~msk);
    endfunction

    assign err_mode = pioc_r[`APS_F_ERR_HI:`APS_F_ERR_LO];
    assign sync_en = pioc_r[`APS_B_SYNC];
    // alternate sync lives outside this register; kept in a local control word
    assign alternate_sync_mode = seq_r[`APS_B_ALT];
    assign sync_hold = sync_en && !alternate_sync_mode && !sync_err_pin_i;
    assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
    assign any_err = |status_err_i;

    // write channel capture, either order
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `APS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awaddr_r)
                    `APS_PIOC_ADDR, `APS_SEQ_ADDR, `APS_IRQ_STAT_ADDR,
                    `APS_IRQ_MASK_ADDR, `APS_STAT_ADDR: s_axi_bresp <= `APS_RESP_OKAY;
                    default: s_axi_bresp <= `APS_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // readies come from flops: each shows whether its slot is free after this edge
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= wr_fire || !(aw_have_r || (s_axi_awvalid && s_axi_awready));
            s_axi_wready <= wr_fire || !(w_have_r || (s_axi_wvalid && s_axi_wready));
            s_axi_arready <= (s_axi_rvalid && s_axi_rready) ||
                !(s_axi_rvalid || (s_axi_arvalid && s_axi_arready));
        end
    end

    // configuration register; bit 8 is only stored, its read depends on pin mode
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pioc_r <= `APS_PIOC_RST;
            seq_r <= `APS_SEQ_RST;
            irq_mask_r <= '0;
        end else if (wr_fire) begin
            case (awaddr_r)
                `APS_PIOC_ADDR: pioc_r <= merge16(pioc_r, wdata_r, wstrb_r,
                    `APS_PIOC_WMASK);
                `APS_SEQ_ADDR: seq_r <= merge16(seq_r, wdata_r, wstrb_r, 16'hffff);
                `APS_IRQ_MASK_ADDR: begin
                    if (wstrb_r[0]) begin
                        irq_mask_r <= wdata_r[`APS_NUM_IRQ-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    assign irq_clr = (wr_fire && awaddr_r == `APS_IRQ_STAT_ADDR && wstrb_r[0]) ?
        wdata_r[`APS_NUM_IRQ-1:0] : '0;
    assign err_in_evt = (err_mode == `APS_ERR_IN) && !sync_err_pin_i && pin_prev_r;
    assign sync_evt = sync_en && sync_err_pin_i && !pin_prev_r;
    assign irq_set = {sq.step, sync_evt, err_in_evt};

    // sticky events: a set in the clearing cycle wins
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_stat_r <= '0;
            pin_prev_r <= 1'b1;
            irq_o <= 1'b0;
        end else begin
            pin_prev_r <= sync_err_pin_i;
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            irq_o <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r);
        end
    end

    // sync/error pin and general pin drivers
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync_err_pin_o <= 1'b0;
            sync_err_pin_oe_o <= 1'b0;
            general_pin_o <= 2'h0;
            general_pin_oe_o <= 2'h0;
            adc_error_o <= 1'b0;
            filter_reset_o <= 1'b0;
        end else begin
            case (err_mode)
                `APS_ERR_OFF: begin
                    sync_err_pin_oe_o <= 1'b0;
                    sync_err_pin_o <= 1'b0;
                    adc_error_o <= any_err;
                end
                `APS_ERR_IN: begin
                    sync_err_pin_oe_o <= 1'b0;
                    sync_err_pin_o <= 1'b0;
                    adc_error_o <= any_err | !sync_err_pin_i;
                end
                `APS_ERR_OD: begin
                    sync_err_pin_o <= 1'b0;
                    sync_err_pin_oe_o <= any_err;
                    adc_error_o <= any_err;
                end
                `APS_ERR_GPO: begin
                    sync_err_pin_o <= pioc_r[`APS_B_ERRDAT];
                    sync_err_pin_oe_o <= 1'b1;
                    adc_error_o <= any_err;
                end
                default: begin
                    sync_err_pin_oe_o <= 1'b0;
                    sync_err_pin_o <= 1'b0;
                    adc_error_o <= any_err;
                end
            endcase
            filter_reset_o <= sync_hold;
            if (pioc_r[`APS_B_MUX]) begin
                general_pin_o <= sq.slot;
                general_pin_oe_o <= 2'h3;
            end else begin
                general_pin_o <= 2'h0;
                // mux off leaves both general pins undriven; pin 1 input enable plays no part
                general_pin_oe_o <= 2'h0;
            end
        end
    end

    always_comb begin
        pioc_rd = pioc_r & `APS_PIOC_WMASK;
        if (err_mode != `APS_ERR_GPO) begin
            pioc_rd[`APS_B_ERRDAT] = sync_err_pin_i;
        end
    end

    // read channel: one cycle after the address is taken
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `APS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `APS_RESP_OKAY;
            case (s_axi_araddr)
                `APS_PIOC_ADDR: s_axi_rdata <= {16'h0000, pioc_rd};
                `APS_SEQ_ADDR: s_axi_rdata <= {16'h0000, seq_r};
                `APS_IRQ_STAT_ADDR: s_axi_rdata <= {29'h0, irq_stat_r};
                `APS_IRQ_MASK_ADDR: s_axi_rdata <= {29'h0, irq_mask_r};
                `APS_STAT_ADDR: s_axi_rdata <= {24'h0, general_pin_i[1] & pioc_r[`APS_B_IPEN1],
                    sync_err_pin_i, sq.conv_busy, sq.settling, filter_reset_o, adc_error_o,
                    sq.slot};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `APS_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign sq.run = |seq_r[3:0];
    assign sq.chan_en = seq_r[3:0];
    assign sq.settle_cyc = seq_r[11:4];
    assign sq.conv_cyc = `APS_CONV_CYC;
    assign sq.sync_hold = sync_hold;
    assign sq.alt_gate = sync_en && alternate_sync_mode && !sync_err_pin_i;

    aps_chan_seq u_seq (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .sq(sq)
    );

    mux_pins_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        pioc_r[`APS_B_MUX] |=> general_pin_oe_o == 2'h3)
        else $error("mux selects not driven");
    od_drive_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (err_mode == `APS_ERR_OD && any_err) |=> sync_err_pin_oe_o && !sync_err_pin_o)
        else $error("open drain not pulled low on error");
    off_mode_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        err_mode == `APS_ERR_OFF |=> !sync_err_pin_oe_o)
        else $error("pin driven while error off");
    err_in_or_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (err_mode == `APS_ERR_IN && !sync_err_pin_i) |=> adc_error_o)
        else $error("error input not merged");
    gpo_level_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        err_mode == `APS_ERR_GPO |=> sync_err_pin_o == $past(pioc_r[`APS_B_ERRDAT]))
        else $error("gpo level wrong");
    reserved_zero_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (pioc_r & ~`APS_PIOC_WMASK) == (`APS_PIOC_RST & ~`APS_PIOC_WMASK))
        else $error("reserved bits changed");
    sync_reset_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        sync_hold |=> filter_reset_o)
        else $error("filter not held in reset");
    od_cover_c: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
        err_mode == `APS_ERR_OD && any_err);
    sync_cover_c: cover property (@(posedge core_clk_i) disable iff (!arst_n_i) sync_evt);
endmodule

//--- aps_pin_partner.sv
// far-side model of the shared sync/error line and the two general pins
`timescale 1ns/1ps
module aps_pin_partner (
    input wire logic core_clk_i, // device clock
    input wire logic sync_err_pin_o, // device drive value
    input wire logic sync_err_pin_oe_o, // device drive enable
    input wire logic [1:0] general_pin_o, // device general pin values
    input wire logic [1:0] general_pin_oe_o, // device general pin enables
    input wire logic line_low_i, // host or another device pulls the line low
    input wire logic pin1_level_i, // external source on general pin 1
    output logic sync_err_pin_i, // resolved sync/error line
    output logic [1:0] general_pin_i // resolved general pins
);
    logic float_r = 1'b0;
    // undriven pin 0 has no pull, so it must not look stable
    always @(posedge core_clk_i) begin
        float_r <= ~float_r;
    end
    // one pull-up shared by all parties: any low driver wins
    assign sync_err_pin_i = (line_low_i || (sync_err_pin_oe_o && !sync_err_pin_o)) ? 1'b0 : 1'b1;
    assign general_pin_i[0] = general_pin_oe_o[0] ? general_pin_o[0] : float_r;
    assign general_pin_i[1] = general_pin_oe_o[1] ? general_pin_o[1] : pin1_level_i;
endmodule

//--- aps_pkg.sv
// types shared by the pin io block
package aps_pkg;
    typedef enum logic [1:0] {
        APS_SEQ_IDLE = 2'b00,
        APS_SEQ_CONV = 2'b01,
        APS_SEQ_SETTLE = 2'b10,
        APS_SEQ_HOLD = 2'b11
    } aps_seq_state_t;
endpackage

//--- aps_seq_if.sv
// carries sequencer controls and its position between the top and the sequencer
`timescale 1ns/1ps
interface aps_seq_if;
    logic run;
    logic [3:0] chan_en;
    logic [7:0] settle_cyc;
    logic [7:0] conv_cyc;
    logic sync_hold;
    logic alt_gate;
    logic [1:0] slot;
    logic step;
    logic settling;
    logic conv_busy;
    modport ctrl (output run, chan_en, settle_cyc, conv_cyc, sync_hold, alt_gate,
        input slot, step, settling, conv_busy);
    modport seq (input run, chan_en, settle_cyc, conv_cyc, sync_hold, alt_gate,
        output slot, step, settling, conv_busy);
endinterface
